// [rxcs_top.sv]
// rxcs_top: receiver lock control, status flags, interrupts and wishbone register slave
//
// Design decisions made here: the Wishbone register port and the address map.
`timescale 1ns/1ns
// Function
// - optional phase FIFO read clock output, given here as a one-cycle enable pulse.
// - FIFO fault flag registered: high the cycle after phase FIFO level reads full or empty.
// - in manual alignment, slip count output reports slipped bits, 0 to 9.
// - data lock flag high in lock-to-data, low in lock-to-reference.
// - with force-data-lock low, force-reference-lock level decides lock state.
// - both lock controls low selects automatic lock mode.
// - controls 01 give manual mode held in lock-to-reference state.
// - force-data-lock high gives manual lock-to-data regardless of other control.
// - input-level flag high when input signal exceeds programmed threshold.
// - input-level flag only offered in basic 8B/10B or PIPE mode.
// - low-speed recovered clock only offered in gigabit Ethernet mode.
module rxcs_top #(
	parameter int FIFO_DEPTH = rxcs_pkg::FIFO_DEPTH,
	parameter int LOCK_DWELL_CYC = rxcs_pkg::LOCK_DWELL_CYC,
	parameter int RECOV_DIV = rxcs_pkg::RECOV_DIV,
	parameter int RDCLK_DIV = rxcs_pkg::RDCLK_DIV,
	parameter bit RDCLK_PRESENT = 1'b1
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// lock controls from fabric, asynchronous
	input wire logic force_data_lock_i,
	input wire logic force_ref_lock_i,
	// receiver front end status
	input wire logic freq_near_i,
	input wire logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_level_i,
	input wire logic slip_req_i,
	input wire logic [7:0] sig_level_i,
	// status to fabric
	output logic data_lock_o,
	output logic manual_lock_o,
	output logic fifo_fault_o,
	output logic [3:0] slip_count_out_o,
	output logic sig_present_o,
	// clock enables to fabric
	output logic fifo_rd_en_o,
	output logic recov_clk_en_o,
	// interrupt
	output logic irq_o
);

	// ----------------------------------------------------------------
	// parameter checks
	// ----------------------------------------------------------------
	localparam int DW = $clog2(LOCK_DWELL_CYC + 1);
	localparam int RW = $clog2(RECOV_DIV + 1);
	localparam int CW = $clog2(RDCLK_DIV + 1);
	localparam int LW = $clog2(FIFO_DEPTH + 1);

	generate
		if (FIFO_DEPTH < 2 || LOCK_DWELL_CYC < 1 || RECOV_DIV < 2 || RDCLK_DIV < 1) begin : g_bad
			$error("rxcs_top: parameter out of range");
		end
	endgenerate

	// ----------------------------------------------------------------
	// lock control synchroniser
	// ----------------------------------------------------------------
	logic [1:0] lock_ctl;

	rxcs_sync #(
		.W(2)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_i({force_data_lock_i, force_ref_lock_i}),
		.sync_o(lock_ctl)
	);

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	rxcs_pkg::rxcs_ctrl_t ctrl_r;
	rxcs_pkg::rxcs_ctrl_t ctrl_nxt;
	rxcs_pkg::rxcs_irq_t irq_stat_r;
	rxcs_pkg::rxcs_irq_t irq_stat_nxt;
	rxcs_pkg::rxcs_irq_t irq_mask_r;
	rxcs_pkg::rxcs_irq_t irq_mask_nxt;
	logic [rxcs_pkg::THRESH_W-1:0] thresh_r;
	logic [rxcs_pkg::THRESH_W-1:0] thresh_nxt;
	logic ack_r;
	logic ack_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;

	// ----------------------------------------------------------------
	// block state
	// ----------------------------------------------------------------
	rxcs_pkg::rxcs_cdr_state_t cdr_r;
	rxcs_pkg::rxcs_cdr_state_t cdr_nxt;
	logic [DW-1:0] dwell_r;
	logic [DW-1:0] dwell_nxt;
	logic [3:0] slip_r;
	logic [3:0] slip_nxt;
	logic fifo_fault_r;
	logic fifo_fault_nxt;
	logic sig_r;
	logic sig_nxt;
	logic [RW-1:0] recov_cnt_r;
	logic [RW-1:0] recov_cnt_nxt;
	logic [CW-1:0] rd_cnt_r;
	logic [CW-1:0] rd_cnt_nxt;
	logic recov_en_r;
	logic recov_en_nxt;
	logic rd_en_r;
	logic rd_en_nxt;

	rxcs_pkg::rxcs_stat_t stat;
	rxcs_pkg::rxcs_irq_t event_set;
	logic wr_stb;
	logic [31:0] wmask;

	// ----------------------------------------------------------------
	// lock state machine
	// ----------------------------------------------------------------
	always_comb begin
		cdr_nxt = cdr_r;
		dwell_nxt = dwell_r;
		if (lock_ctl[1]) begin
			cdr_nxt = rxcs_pkg::RXCS_MAN_LTD;
			dwell_nxt = '0;
		end else if (lock_ctl[0]) begin
			cdr_nxt = rxcs_pkg::RXCS_MAN_LTR;
			dwell_nxt = '0;
		end else begin
			case (cdr_r)
				rxcs_pkg::RXCS_AUTO_LTR: begin
					if (!freq_near_i) begin
						dwell_nxt = '0;
					end else if (dwell_r == DW'(LOCK_DWELL_CYC - 1)) begin
						cdr_nxt = rxcs_pkg::RXCS_AUTO_LTD;
						dwell_nxt = '0;
					end else begin
						dwell_nxt = dwell_r + DW'(1);
					end
				end
				rxcs_pkg::RXCS_AUTO_LTD: begin
					if (!freq_near_i) begin
						cdr_nxt = rxcs_pkg::RXCS_AUTO_LTR;
					end
				end
				default: begin
					cdr_nxt = rxcs_pkg::RXCS_AUTO_LTR;
					dwell_nxt = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cdr_r <= rxcs_pkg::RXCS_AUTO_LTR;
			dwell_r <= '0;
		end else begin
			cdr_r <= cdr_nxt;
			dwell_r <= dwell_nxt;
		end
	end

	// ----------------------------------------------------------------
	// status flags, slip count and clock enables
	// ----------------------------------------------------------------
	always_comb begin
		fifo_fault_nxt = (fifo_level_i == '0) || (fifo_level_i == LW'(FIFO_DEPTH));
		sig_nxt = (ctrl_r.basic_8b10b || ctrl_r.pipe_mode) && (sig_level_i > thresh_r);
		slip_nxt = slip_r;
		if (!ctrl_r.manual_align) begin
			slip_nxt = 4'h0;
		end else if (slip_req_i) begin
			slip_nxt = (slip_r == rxcs_pkg::SLIP_MAX) ? 4'h0 : slip_r + 4'h1;
		end
		recov_cnt_nxt = '0;
		recov_en_nxt = 1'b0;
		if (ctrl_r.gigabit_ethernet_mode) begin
			recov_en_nxt = (recov_cnt_r == RW'(RECOV_DIV - 1));
			recov_cnt_nxt = recov_en_nxt ? '0 : recov_cnt_r + RW'(1);
		end
		rd_cnt_nxt = '0;
		rd_en_nxt = 1'b0;
		if (RDCLK_PRESENT && ctrl_r.rdclk_en) begin
			rd_en_nxt = (rd_cnt_r == CW'(RDCLK_DIV - 1));
			rd_cnt_nxt = rd_en_nxt ? '0 : rd_cnt_r + CW'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fifo_fault_r <= 1'b0;
			sig_r <= 1'b0;
			slip_r <= 4'h0;
			recov_cnt_r <= '0;
			recov_en_r <= 1'b0;
			rd_cnt_r <= '0;
			rd_en_r <= 1'b0;
		end else begin
			fifo_fault_r <= fifo_fault_nxt;
			sig_r <= sig_nxt;
			slip_r <= slip_nxt;
			recov_cnt_r <= recov_cnt_nxt;
			recov_en_r <= recov_en_nxt;
			rd_cnt_r <= rd_cnt_nxt;
			rd_en_r <= rd_en_nxt;
		end
	end

	// ----------------------------------------------------------------
	// register bus and interrupts
	// ----------------------------------------------------------------
	always_comb begin
		stat.data_lock = (cdr_r == rxcs_pkg::RXCS_AUTO_LTD) || (cdr_r == rxcs_pkg::RXCS_MAN_LTD);
		stat.manual_lock = cdr_r[1];
		stat.fifo_fault = fifo_fault_r;
		stat.sig_present = sig_r;
		stat.slip_count = slip_r;
		event_set.lock_change = (cdr_nxt[0] != cdr_r[0]) || (cdr_nxt[1] != cdr_r[1]);
		event_set.fifo_fault_rise = fifo_fault_nxt && !fifo_fault_r;
		event_set.sig_rise = sig_nxt && !sig_r;
		wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
		wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
		ack_nxt = wb_cyc_i && wb_stb_i && !ack_r;
		ctrl_nxt = ctrl_r;
		irq_mask_nxt = irq_mask_r;
		thresh_nxt = thresh_r;
		irq_stat_nxt = irq_stat_r;
		rdata_nxt = rdata_r;
		if (wr_stb) begin
			case (wb_adr_i)
				rxcs_pkg::ADDR_CTRL: begin
					ctrl_nxt = rxcs_pkg::rxcs_ctrl_t'((wb_dat_i[rxcs_pkg::CTRL_W-1:0] & wmask[rxcs_pkg::CTRL_W-1:0])
						| (ctrl_r & ~wmask[rxcs_pkg::CTRL_W-1:0]));
				end
				rxcs_pkg::ADDR_IRQ_STAT: begin
					irq_stat_nxt = rxcs_pkg::rxcs_irq_t'(irq_stat_r & ~(wb_dat_i[rxcs_pkg::IRQ_W-1:0]
						& wmask[rxcs_pkg::IRQ_W-1:0]));
				end
				rxcs_pkg::ADDR_IRQ_MASK: begin
					irq_mask_nxt = rxcs_pkg::rxcs_irq_t'((wb_dat_i[rxcs_pkg::IRQ_W-1:0] & wmask[rxcs_pkg::IRQ_W-1:0])
						| (irq_mask_r & ~wmask[rxcs_pkg::IRQ_W-1:0]));
				end
				rxcs_pkg::ADDR_THRESH: begin
					thresh_nxt = (wb_dat_i[rxcs_pkg::THRESH_W-1:0] & wmask[rxcs_pkg::THRESH_W-1:0])
						| (thresh_r & ~wmask[rxcs_pkg::THRESH_W-1:0]);
				end
				default: begin
					ctrl_nxt = ctrl_r;
				end
			endcase
		end
		// set wins over a same-cycle clear
		irq_stat_nxt = irq_stat_nxt | event_set;
		if (ack_nxt) begin
			case (wb_adr_i)
				rxcs_pkg::ADDR_CTRL: rdata_nxt = {27'h0000000, ctrl_r};
				rxcs_pkg::ADDR_STAT: rdata_nxt = {24'h000000, stat};
				rxcs_pkg::ADDR_IRQ_STAT: rdata_nxt = {29'h00000000, irq_stat_r};
				rxcs_pkg::ADDR_IRQ_MASK: rdata_nxt = {29'h00000000, irq_mask_r};
				rxcs_pkg::ADDR_THRESH: rdata_nxt = {24'h000000, thresh_r};
				default: rdata_nxt = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r <= rxcs_pkg::rxcs_ctrl_t'(rxcs_pkg::CTRL_RST);
			irq_stat_r <= rxcs_pkg::rxcs_irq_t'(3'h0);
			irq_mask_r <= rxcs_pkg::rxcs_irq_t'(rxcs_pkg::IRQ_MASK_RST);
			thresh_r <= rxcs_pkg::THRESH_RST;
			ack_r <= 1'b0;
			rdata_r <= 32'h00000000;
		end else begin
			ctrl_r <= ctrl_nxt;
			irq_stat_r <= irq_stat_nxt;
			irq_mask_r <= irq_mask_nxt;
			thresh_r <= thresh_nxt;
			ack_r <= ack_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdata_r;
	assign data_lock_o = stat.data_lock;
	assign manual_lock_o = stat.manual_lock;
	assign fifo_fault_o = fifo_fault_r;
	assign slip_count_out_o = slip_r;
	assign sig_present_o = sig_r;
	assign fifo_rd_en_o = rd_en_r;
	assign recov_clk_en_o = recov_en_r;
	assign irq_o = |(irq_stat_r & irq_mask_r);

endmodule // rxcs_top

// [rxcs_pkg.sv]
// rxcs_pkg: register map, field layouts, states and timing of the receiver control and status block
package rxcs_pkg;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
	localparam logic [7:0] ADDR_THRESH = 8'h10;

	// ----------------------------------------------------------------
	// field layouts
	// ----------------------------------------------------------------
	typedef struct packed {
		logic rdclk_en;
		logic manual_align;
		logic gigabit_ethernet_mode;
		logic pipe_mode;
		logic basic_8b10b;
	} rxcs_ctrl_t;

	typedef struct packed {
		logic [3:0] slip_count;
		logic manual_lock;
		logic sig_present;
		logic fifo_fault;
		logic data_lock;
	} rxcs_stat_t;

	typedef struct packed {
		logic sig_rise;
		logic fifo_fault_rise;
		logic lock_change;
	} rxcs_irq_t;

	localparam int CTRL_W = 5;
	localparam int STAT_W = 8;
	localparam int IRQ_W = 3;
	localparam int THRESH_W = 8;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [4:0] CTRL_RST = 5'h00;
	localparam logic [2:0] IRQ_MASK_RST = 3'h0;
	localparam logic [7:0] THRESH_RST = 8'h80;

	// ----------------------------------------------------------------
	// lock states and slip range
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		RXCS_AUTO_LTR = 2'b00,
		RXCS_AUTO_LTD = 2'b01,
		RXCS_MAN_LTR = 2'b10,
		RXCS_MAN_LTD = 2'b11
	} rxcs_cdr_state_t;

	localparam logic [3:0] SLIP_MAX = 4'h9;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int LOCK_DWELL_NS = 1000;
	localparam int LOCK_DWELL_CYC = (LOCK_DWELL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECOV_DIV = 10;
	localparam int RDCLK_DIV = 2;
	localparam int FIFO_DEPTH = 8;

endpackage

// [rxcs_sync.sv]
// rxcs_sync: two-flop level synchroniser, one lane per bit
`timescale 1ns/1ns
module rxcs_sync #(
	parameter int W = 2
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// levels
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);

	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_lane
			logic meta_r;
			logic meta_nxt;
			logic hold_r;
			logic hold_nxt;
			always_comb begin
				meta_nxt = async_i[g];
				hold_nxt = meta_r;
			end
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					meta_r <= 1'b0;
					hold_r <= 1'b0;
				end else begin
					meta_r <= meta_nxt;
					hold_r <= hold_nxt;
				end
			end
			assign sync_o[g] = hold_r;
		end
	endgenerate

endmodule // rxcs_sync

// [rxcs_monitor.sv]
// rxcs_monitor: port-level assertions for the receiver control and status block
`timescale 1ns/1ns
module rxcs_monitor #(
	parameter int FIFO_DEPTH = 8
) (
	// clock and reset
	input logic clk_i,
	input logic rst_i,
	// bus handshake
	input logic wb_cyc_i,
	input logic wb_stb_i,
	input logic wb_ack_o,
	// inputs watched
	input logic force_data_lock_i,
	input logic force_ref_lock_i,
	input logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_level_i,
	input logic slip_req_i,
	// outputs watched
	input logic data_lock_o,
	input logic manual_lock_o,
	input logic fifo_fault_o,
	input logic [3:0] slip_count_out_o,
	input logic fifo_rd_en_o,
	input logic recov_clk_en_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_fault_level: assert property (
		!$past(rst_i) |-> fifo_fault_o == ($past(fifo_level_i) == 0 || $past(fifo_level_i) == FIFO_DEPTH))
		else $error("fifo fault flag wrong");
	a_slip_range: assert property (slip_count_out_o <= 4'h9)
		else $error("slip count above nine");
	a_slip_step: assert property (
		$past(slip_req_i) && !$past(rst_i) |-> slip_count_out_o == 4'h0 ||
		slip_count_out_o == ($past(slip_count_out_o) == 4'h9 ? 4'h0 : $past(slip_count_out_o) + 4'h1))
		else $error("slip count step wrong");
	a_force_data: assert property (force_data_lock_i [*5] |-> data_lock_o && manual_lock_o)
		else $error("forced data lock not taken");
	a_force_ref: assert property (
		(!force_data_lock_i && force_ref_lock_i) [*5] |-> manual_lock_o && !data_lock_o)
		else $error("forced reference lock not taken");
	a_auto_mode: assert property ((!force_data_lock_i && !force_ref_lock_i) [*5] |-> !manual_lock_o)
		else $error("automatic mode not taken");
	a_rdclk_pulse: assert property (fifo_rd_en_o |=> !fifo_rd_en_o)
		else $error("read clock enable too long");
	a_recov_pulse: assert property (recov_clk_en_o |=> !recov_clk_en_o [*8])
		else $error("recovered clock enable too often");
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus access not acknowledged");
endmodule // rxcs_monitor

bind rxcs_top rxcs_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) u_mon (.*);

// [rxcs_fabric_model.sv]
// rxcs_fabric_model: fabric logic driving the lock controls
`timescale 1ns/1ns
module rxcs_fabric_model (
	// clock
	input logic clk_i,
	// requested pair {data, ref}
	input logic [1:0] pair_i,
	// lock controls
	output logic force_data_lock_o,
	output logic force_ref_lock_o
);
	logic [1:0] cur_r = 2'h0;
	logic [1:0] age_r = 2'h0;

	// each level is held at least four cycles
	always_ff @(posedge clk_i) begin
		if (age_r != 2'h3) begin
			age_r <= age_r + 2'h1;
		end else if (pair_i != cur_r) begin
			cur_r <= pair_i;
			age_r <= 2'h0;
		end
	end

	assign force_data_lock_o = cur_r[1];
	assign force_ref_lock_o = cur_r[0];
endmodule // rxcs_fabric_model

// [tb.sv]
// tb: self-checking testbench for the receiver control and status block
`timescale 1ns/1ns
module tb;
	logic clk_i = 1'b0, rst_i = 1'b1, req = 1'b0, we = 1'b0, fnear = 1'b0, slip = 1'b0;
	logic [7:0] adr = 8'h00, sig = 8'h00;
	logic [31:0] dat = 32'h0, rdat, q;
	logic [3:0] lvl = 4'h4, slc;
	logic [1:0] pair = 2'h0;
	logic ack, fdl, frl, dlk, mlk, flt, sp, rde, rce, irq;
	logic [7:0] ra[4] = '{8'h00, 8'h0C, 8'h10, 8'h20};
	logic [31:0] re[4] = '{32'h0, 32'h0, 32'h80, 32'h0};
	logic [3:0] fl[4] = '{4'h0, 4'h1, 4'h7, 4'h8};
	logic fe[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
	int n_errors = 0, num_checks = 0, cf, cr;

	rxcs_fabric_model u_fab (.clk_i(clk_i), .pair_i(pair), .force_data_lock_o(fdl), .force_ref_lock_o(frl));
	rxcs_top #(.LOCK_DWELL_CYC(4)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.force_data_lock_i(fdl), .force_ref_lock_i(frl), .freq_near_i(fnear), .fifo_level_i(lvl),
		.slip_req_i(slip), .sig_level_i(sig), .data_lock_o(dlk), .manual_lock_o(mlk), .fifo_fault_o(flt),
		.slip_count_out_o(slc), .sig_present_o(sp), .fifo_rd_en_o(rde), .recov_clk_en_o(rce), .irq_o(irq));

	initial forever #2 clk_i = ~clk_i;

	// --------
	// tasks
	// --------
	task automatic w(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			n_errors++;
			$display("MISMATCH %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		req <= 1'b1;
		we <= wr;
		adr <= a;
		dat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rdat;
		req <= 1'b0;
	endtask
	task automatic sg(input logic [31:0] c, input logic [7:0] l, input logic e);
		xfer(1'b1, 8'h00, c);
		sig <= l;
		w(3);
		chk(sp, e);
	endtask
	task automatic ck(input logic [31:0] c, input logic [31:0] er, input logic [31:0] ec);
		xfer(1'b1, 8'h00, c);
		w(4);
		cf = 0;
		cr = 0;
		repeat (20) begin
			@(posedge clk_i);
			cf += rde;
			cr += rce;
		end
		chk(32'(cf), er);
		chk(32'(cr), ec);
	endtask
	task automatic results();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// --------
	// tests
	// --------
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (ra[i]) begin
			xfer(1'b0, ra[i], 32'h0);
			chk(q, re[i]);
		end
		xfer(1'b1, 8'h0C, 32'h7);
		xfer(1'b1, 8'h08, 32'h7);
		chk(irq, 1'b0);
		lvl <= 4'h0;
		w(3);
		chk(irq, 1'b1);
		xfer(1'b0, 8'h08, 32'h0);
		chk(q, 32'h2);
		xfer(1'b1, 8'h0C, 32'h0);
		w(1);
		chk(irq, 1'b0);
		xfer(1'b1, 8'h08, 32'h2);
		xfer(1'b0, 8'h08, 32'h0);
		chk(q, 32'h0);
		foreach (fl[i]) begin
			lvl <= fl[i];
			w(3);
			chk(flt, fe[i]);
		end
		lvl <= 4'h4;
		fnear <= 1'b1;
		for (int p = 0; p < 4; p++) begin
			pair <= 2'(p);
			w(14);
			chk(dlk, p != 1);
			chk(mlk, p != 0);
		end
		pair <= 2'h0;
		w(14);
		chk(dlk, 1'b1);
		chk(mlk, 1'b0);
		fnear <= 1'b0;
		w(3);
		chk(dlk, 1'b0);
		fnear <= 1'b1;
		w(2);
		chk(dlk, 1'b0);
		w(8);
		chk(dlk, 1'b1);
		xfer(1'b1, 8'h00, 32'h08);
		repeat (12) begin
			slip <= 1'b1;
			@(posedge clk_i);
			slip <= 1'b0;
			@(posedge clk_i);
		end
		w(2);
		chk(slc, 4'h2);
		xfer(1'b0, 8'h04, 32'h0);
		chk(q & 32'hF0, 32'h20);
		sg(32'h01, 8'h81, 1'b1);
		sg(32'h01, 8'h80, 1'b0);
		sg(32'h02, 8'h81, 1'b1);
		sg(32'h00, 8'h81, 1'b0);
		xfer(1'b0, 8'h08, 32'h0);
		chk(q, 32'h7);
		chk(slc, 4'h0);
		ck(32'h00, 32'h0, 32'h0);
		ck(32'h14, 32'hA, 32'h2);
		results();
	end

	initial begin
		#20000;
		n_errors++;
		results();
	end
endmodule // tb
